// file: adcscp_defines.vh
`ifndef ADCSCP_DEFINES_VH
`define ADCSCP_DEFINES_VH

// Register addresses, 13-bit instruction address field
`define ADCSCP_ADDR_PORT_CFG 13'h0000
`define ADCSCP_ADDR_CHAN_IDX 13'h0005
`define ADCSCP_ADDR_SYNC_CTRL 13'h003a
`define ADCSCP_ADDR_NS_CTRL 13'h003c
`define ADCSCP_ADDR_NS_TUNE 13'h003e
`define ADCSCP_ADDR_XFER 13'h00ff

// Reset values
`define ADCSCP_RST_LSB_FIRST 1'h0
`define ADCSCP_RST_CHAN_IDX 2'h3
`define ADCSCP_RST_SYNC_CTRL 8'h00
`define ADCSCP_RST_NS_CTRL 4'h0
`define ADCSCP_RST_NS_TUNE 6'h00
`define ADCSCP_RST_BAND 8'h00

// Field positions
`define ADCSCP_CFG_LSB_BIT 6
`define ADCSCP_CFG_LSB_MIRROR 1
`define ADCSCP_XFER_BIT 0
`define ADCSCP_SYNC_EN_BIT 1
`define ADCSCP_SYNC_NEXT_BIT 2
`define ADCSCP_NS_EN_BIT 0
`define ADCSCP_NS_MODE_MSB 3
`define ADCSCP_NS_MODE_LSB 1
`define ADCSCP_NS_TW_MSB 5
`define ADCSCP_INSTR_RW_BIT 15
`define ADCSCP_INSTR_LEN_MSB 14
`define ADCSCP_INSTR_LEN_LSB 13
`define ADCSCP_INSTR_ADDR_MSB 12

// Noise shaper modes and band figures, in steps of 0.5 percent of fs
`define ADCSCP_NS_MODE_NARROW 3'h0
`define ADCSCP_NS_MODE_WIDE 3'h1
`define ADCSCP_TW_MAX_NARROW 6'h38
`define ADCSCP_TW_MAX_WIDE 6'h21
`define ADCSCP_CTR_OFS_NARROW 8'h16
`define ADCSCP_HI_OFS_NARROW 8'h2c
`define ADCSCP_CTR_OFS_WIDE 8'h21
`define ADCSCP_HI_OFS_WIDE 8'h42

// Frame counts
`define ADCSCP_INSTR_LAST 4'hf
`define ADCSCP_BYTE_LAST 4'h7
`define ADCSCP_LEN_STREAM 2'h3
`define ADCSCP_STRAP_WAIT 2'h3

`endif

// file: adcscp_sync3.v
`timescale 1ns/100ps

module adcscp_sync3 #(
  parameter [0:0] RST_VAL = 1'h0
) (
  input wire clk,
  input wire rst,
  input wire din,
  output wire dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg lvl_reg;

  // Level only moves once the last two stages agree
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      lvl_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        lvl_reg <= s3_reg;
    end
  end

  assign dout = lvl_reg;

endmodule // adcscp_sync3

// file: adcscp_top.v
// Functional notes
// [RULE1] Three wires: clock, bidirectional data, select low
// [RULE2] Frame starts at select low plus clock rise
// [RULE3] Select held low streams bytes without end; code streams only for length bits 11, other lengths stop after their count
// [RULE4] Select high between bytes stalls, frame continues; code ends streaming (length 11) frames instead
// [RULE5] Select high: port pins released, secondaries on; code keeps secondaries off while a frame is stalled between bytes
// [RULE6] Frame opens with sixteen-bit instruction
// [RULE7] Data bytes follow, count from length bits
// [RULE8] Leading instruction bit selects read or write; in LSB-first mode code takes it from the last bit received
// [RULE9] Readback turns data line to output
// [RULE10] MSB first by default, LSB first selectable
// [RULE11] Master keeps serial lines quiet when critical
// [RULE12] Strapped pin levels latched when port unused
// [RULE13] Noise shaper settings held per channel
// [RULE14] Mode 000 selects narrow 22 percent band
// [RULE15] Mode 001 selects wide 33 percent band
// [RULE16] Narrow mode accepts tuning words 0 to 56
// [RULE17] Wide mode accepts tuning words 0 to 33
// [RULE18] Narrow edges: TW, plus 22, plus 44 steps
// [RULE19] Wide edges: TW, plus 33, plus 66 steps
// [RULE20] Divider resyncs on next or every pulse
// [RULE21] Align input retimed into sample clock
// [RULE22] Shadowed writes applied by self-clearing transfer
// [RULE23] Channel index steers per-channel access
// [RULE24] Select rise ends frame and releases line
`timescale 1ns/100ps
`include "adcscp_defines.vh"

module adcscp_top (
  input wire CLK,
  input wire RST,
  input wire SCLK,
  input wire CSB_N,
  input wire SDIO_I,
  output wire SDIO_O,
  output wire SDIO_OE_N,
  input wire SYNC_IN,
  output wire SPI_SECONDARY_EN,
  output wire STRAP_VALID,
  output wire STRAP_SCLK_FUNC,
  output wire STRAP_SDIO_FUNC,
  output wire DIV_RESYNC,
  output wire SYNC_ARMED,
  output wire NS_EN_A,
  output wire NS_EN_B,
  output wire [2:0] NS_MODE_A,
  output wire [2:0] NS_MODE_B,
  output wire NS_WIDE_A,
  output wire NS_WIDE_B,
  output wire [5:0] NS_TW_A,
  output wire [5:0] NS_TW_B,
  output wire NS_TW_OK_A,
  output wire NS_TW_OK_B,
  output wire [7:0] NS_LO_A,
  output wire [7:0] NS_LO_B,
  output wire [7:0] NS_CTR_A,
  output wire [7:0] NS_CTR_B,
  output wire [7:0] NS_HI_A,
  output wire [7:0] NS_HI_B
);

  localparam ST_INSTR = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_DONE = 3'h4;
  localparam [3:0] PIN_RST = 4'h2;

  function [7:0] band_ofs;
    input [2:0] mode;
    input upper;
    begin
      if (mode == `ADCSCP_NS_MODE_NARROW)
        band_ofs = upper ? `ADCSCP_HI_OFS_NARROW : `ADCSCP_CTR_OFS_NARROW;
      else if (mode == `ADCSCP_NS_MODE_WIDE)
        band_ofs = upper ? `ADCSCP_HI_OFS_WIDE : `ADCSCP_CTR_OFS_WIDE;
      else
        band_ofs = `ADCSCP_RST_BAND;
    end
  endfunction

  function tw_ok;
    input [2:0] mode;
    input [5:0] tw;
    begin
      if (mode == `ADCSCP_NS_MODE_NARROW)
        tw_ok = (tw <= `ADCSCP_TW_MAX_NARROW);
      else if (mode == `ADCSCP_NS_MODE_WIDE)
        tw_ok = (tw <= `ADCSCP_TW_MAX_WIDE);
      else
        tw_ok = 1'h0;
    end
  endfunction

  wire [3:0] pin_raw;
  wire [3:0] pin_lvl;
  assign pin_raw = {SYNC_IN, SDIO_I, CSB_N, SCLK};

  // Pins are asynchronous; the serial clock must stay well below CLK/8
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      adcscp_sync3 #(
        .RST_VAL(PIN_RST[gi])
      ) u_sync (
        .clk(CLK),
        .rst(RST),
        .din(pin_raw[gi]),
        .dout(pin_lvl[gi])
      ); // RULE1 RULE21
    end
  endgenerate

  wire sclk_lvl;
  wire csb_lvl;
  wire sdi_lvl;
  wire sync_lvl;
  assign sclk_lvl = pin_lvl[0];
  assign csb_lvl = pin_lvl[1];
  assign sdi_lvl = pin_lvl[2];
  assign sync_lvl = pin_lvl[3];

  reg sclk_prev_reg;
  reg csb_prev_reg;
  reg sync_prev_reg;
  always @(posedge CLK)
  begin
    if (RST)
    begin
      sclk_prev_reg <= 1'h0;
      csb_prev_reg <= 1'h1;
      sync_prev_reg <= 1'h0;
    end
    else
    begin
      sclk_prev_reg <= sclk_lvl;
      csb_prev_reg <= csb_lvl;
      sync_prev_reg <= sync_lvl;
    end
  end

  wire sclk_rise;
  wire sclk_fall;
  wire csb_rise;
  wire sync_rise;
  assign sclk_rise = sclk_lvl & ~sclk_prev_reg & ~csb_lvl; // RULE2
  assign sclk_fall = ~sclk_lvl & sclk_prev_reg & ~csb_lvl;
  assign csb_rise = csb_lvl & ~csb_prev_reg;
  assign sync_rise = sync_lvl & ~sync_prev_reg;

  reg lsb_first_reg;
  reg [1:0] chan_sel_reg;
  reg [7:0] sync_sh_reg;
  reg [7:0] sync_act_reg;
  reg xfer_reg;
  reg [2:0] state_reg, state_next;
  reg [15:0] instr_reg, instr_next;
  reg [3:0] bit_cnt_reg, bit_cnt_next;
  reg [7:0] rx_reg, rx_next;
  reg [7:0] tx_reg, tx_next;
  reg [12:0] addr_reg, addr_next;
  reg rw_reg, rw_next;
  reg [1:0] len_reg, len_next;
  reg [1:0] left_reg, left_next;
  reg drive_reg, drive_next;
  reg sdo_reg, sdo_next;
  reg wr_stb_reg, wr_stb_next;
  reg [12:0] wr_addr_reg, wr_addr_next;
  reg [7:0] wr_data_reg, wr_data_next;
  reg [7:0] rd_data;
  wire [7:0] ctrl_sh_w;
  wire [11:0] tune_sh_w;

  wire [15:0] instr_sh;
  wire [7:0] rx_sh;
  wire [12:0] addr_step;
  wire [12:0] rd_addr;
  assign instr_sh = lsb_first_reg ? {sdi_lvl, instr_reg[15:1]} : {instr_reg[14:0], sdi_lvl}; // RULE10
  assign rx_sh = lsb_first_reg ? {sdi_lvl, rx_reg[7:1]} : {rx_reg[6:0], sdi_lvl}; // RULE10
  assign addr_step = lsb_first_reg ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
  assign rd_addr = (state_reg == ST_INSTR) ? instr_sh[`ADCSCP_INSTR_ADDR_MSB:0] : addr_step;

  always @*
  begin
    state_next = state_reg;
    instr_next = instr_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    len_next = len_reg;
    left_next = left_reg;
    drive_next = drive_reg;
    sdo_next = sdo_reg;
    wr_stb_next = 1'h0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    if (csb_rise)
    begin
      drive_next = 1'h0; // RULE5 RULE24
      // Mid-byte, finished or streaming frames end; other byte boundaries stall
      if (state_reg == ST_DONE || bit_cnt_reg[2:0] != 3'h0 ||
          (state_reg == ST_DATA && len_reg == `ADCSCP_LEN_STREAM)) // RULE3
      begin
        state_next = ST_INSTR; // RULE24
        bit_cnt_next = 4'h0;
      end // RULE4
    end
    else if (sclk_rise)
    begin
      case (state_reg)
        ST_INSTR:
        begin
          instr_next = instr_sh;
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `ADCSCP_INSTR_LAST) // RULE6
          begin
            rw_next = instr_sh[`ADCSCP_INSTR_RW_BIT]; // RULE8
            len_next = instr_sh[`ADCSCP_INSTR_LEN_MSB:`ADCSCP_INSTR_LEN_LSB]; // RULE7
            left_next = instr_sh[`ADCSCP_INSTR_LEN_MSB:`ADCSCP_INSTR_LEN_LSB];
            addr_next = instr_sh[`ADCSCP_INSTR_ADDR_MSB:0];
            tx_next = rd_data;
            bit_cnt_next = 4'h0;
            state_next = ST_DATA;
          end
        end
        ST_DATA:
        begin
          rx_next = rx_sh;
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `ADCSCP_BYTE_LAST) // RULE7
          begin
            bit_cnt_next = 4'h0;
            if (!rw_reg)
            begin
              wr_stb_next = 1'h1;
              wr_addr_next = addr_reg;
              wr_data_next = rx_sh;
            end
            addr_next = addr_step;
            tx_next = rd_data;
            if (len_reg != `ADCSCP_LEN_STREAM) // RULE3
            begin
              if (left_reg == 2'h0)
                state_next = ST_DONE;
              else
                left_next = left_reg - 2'h1;
            end
          end
        end
        ST_DONE:
          state_next = ST_DONE;
        default:
          state_next = ST_INSTR;
      endcase
    end
    else if (sclk_fall && state_reg == ST_DATA && rw_reg)
    begin
      // Bits change on the falling edge so the master samples on the rise
      drive_next = 1'h1; // RULE9
      sdo_next = lsb_first_reg ? tx_reg[0] : tx_reg[7]; // RULE10
      tx_next = lsb_first_reg ? {1'h0, tx_reg[7:1]} : {tx_reg[6:0], 1'h0};
    end
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_INSTR;
      instr_reg <= 16'h0000;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= 13'h0000;
      rw_reg <= 1'h0;
      len_reg <= 2'h0;
      left_reg <= 2'h0;
      drive_reg <= 1'h0;
      sdo_reg <= 1'h0;
      wr_stb_reg <= 1'h0;
      wr_addr_reg <= 13'h0000;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      len_reg <= len_next;
      left_reg <= left_next;
      drive_reg <= drive_next;
      sdo_reg <= sdo_next;
      wr_stb_reg <= wr_stb_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // Readback shows the shadow copies; both channels selected reads A
  always @*
  begin
    rd_data = 8'h00;
    if (rd_addr == `ADCSCP_ADDR_PORT_CFG)
      rd_data = {1'h0, lsb_first_reg, 4'h0, lsb_first_reg, 1'h0};
    else if (rd_addr == `ADCSCP_ADDR_CHAN_IDX)
      rd_data = {6'h00, chan_sel_reg};
    else if (rd_addr == `ADCSCP_ADDR_SYNC_CTRL)
      rd_data = sync_sh_reg;
    else if (rd_addr == `ADCSCP_ADDR_NS_CTRL)
      rd_data = {4'h0, chan_sel_reg[0] ? ctrl_sh_w[3:0] : ctrl_sh_w[7:4]}; // RULE23
    else if (rd_addr == `ADCSCP_ADDR_NS_TUNE)
      rd_data = {2'h0, chan_sel_reg[0] ? tune_sh_w[5:0] : tune_sh_w[11:6]}; // RULE23
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      lsb_first_reg <= `ADCSCP_RST_LSB_FIRST;
      chan_sel_reg <= `ADCSCP_RST_CHAN_IDX;
      sync_sh_reg <= `ADCSCP_RST_SYNC_CTRL;
      xfer_reg <= 1'h0;
    end
    else
    begin
      xfer_reg <= 1'h0;
      if (wr_stb_reg)
      begin
        if (wr_addr_reg == `ADCSCP_ADDR_PORT_CFG)
          lsb_first_reg <= wr_data_reg[`ADCSCP_CFG_LSB_BIT] |
                           wr_data_reg[`ADCSCP_CFG_LSB_MIRROR]; // RULE10
        else if (wr_addr_reg == `ADCSCP_ADDR_CHAN_IDX)
          chan_sel_reg <= wr_data_reg[1:0];
        else if (wr_addr_reg == `ADCSCP_ADDR_SYNC_CTRL)
          sync_sh_reg <= wr_data_reg;
        else if (wr_addr_reg == `ADCSCP_ADDR_XFER)
          xfer_reg <= wr_data_reg[`ADCSCP_XFER_BIT]; // RULE22
      end
    end
  end

  wire [1:0] en_w;
  wire [5:0] mode_w;
  wire [1:0] wide_w;
  wire [11:0] tw_w;
  wire [1:0] ok_w;
  wire [15:0] lo_w;
  wire [15:0] ctr_w;
  wire [15:0] hi_w;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      reg [3:0] ctrl_sh_reg;
      reg [5:0] tune_sh_reg;
      reg [3:0] ctrl_act_reg;
      reg [5:0] tune_act_reg;
      reg wide_reg;
      reg ok_reg;
      reg [7:0] lo_reg;
      reg [7:0] ctr_reg;
      reg [7:0] hi_reg;
      wire [2:0] mode_sh;
      assign mode_sh = ctrl_sh_reg[`ADCSCP_NS_MODE_MSB:`ADCSCP_NS_MODE_LSB];
      always @(posedge CLK)
      begin
        if (RST)
        begin
          ctrl_sh_reg <= `ADCSCP_RST_NS_CTRL;
          tune_sh_reg <= `ADCSCP_RST_NS_TUNE;
          ctrl_act_reg <= `ADCSCP_RST_NS_CTRL;
          tune_act_reg <= `ADCSCP_RST_NS_TUNE;
          wide_reg <= 1'h0;
          ok_reg <= 1'h0;
          lo_reg <= `ADCSCP_RST_BAND;
          ctr_reg <= `ADCSCP_RST_BAND;
          hi_reg <= `ADCSCP_RST_BAND;
        end
        else
        begin
          if (wr_stb_reg && chan_sel_reg[ch]) // RULE13 RULE23
          begin
            if (wr_addr_reg == `ADCSCP_ADDR_NS_CTRL)
              ctrl_sh_reg <= wr_data_reg[3:0];
            else if (wr_addr_reg == `ADCSCP_ADDR_NS_TUNE)
              tune_sh_reg <= wr_data_reg[`ADCSCP_NS_TW_MSB:0];
          end
          if (xfer_reg) // RULE22
          begin
            ctrl_act_reg <= ctrl_sh_reg;
            tune_act_reg <= tune_sh_reg;
            wide_reg <= (mode_sh == `ADCSCP_NS_MODE_WIDE); // RULE14 RULE15
            ok_reg <= tw_ok(mode_sh, tune_sh_reg); // RULE16 RULE17
            lo_reg <= {2'h0, tune_sh_reg};
            ctr_reg <= {2'h0, tune_sh_reg} + band_ofs(mode_sh, 1'h0); // RULE18 RULE19
            hi_reg <= {2'h0, tune_sh_reg} + band_ofs(mode_sh, 1'h1); // RULE18 RULE19
          end
        end
      end
      assign ctrl_sh_w[ch*4 +: 4] = ctrl_sh_reg;
      assign tune_sh_w[ch*6 +: 6] = tune_sh_reg;
      assign en_w[ch] = ctrl_act_reg[`ADCSCP_NS_EN_BIT];
      assign mode_w[ch*3 +: 3] = ctrl_act_reg[`ADCSCP_NS_MODE_MSB:`ADCSCP_NS_MODE_LSB];
      assign wide_w[ch] = wide_reg;
      assign tw_w[ch*6 +: 6] = tune_act_reg;
      assign ok_w[ch] = ok_reg;
      assign lo_w[ch*8 +: 8] = lo_reg;
      assign ctr_w[ch*8 +: 8] = ctr_reg;
      assign hi_w[ch*8 +: 8] = hi_reg;
    end
  endgenerate

  reg armed_reg;
  reg resync_reg;
  wire sync_fire;
  assign sync_fire = sync_rise & sync_act_reg[`ADCSCP_SYNC_EN_BIT] &
                     (~sync_act_reg[`ADCSCP_SYNC_NEXT_BIT] | armed_reg); // RULE20

  // A new transfer re-arms one-shot mode and wins over a same-cycle fire
  always @(posedge CLK)
  begin
    if (RST)
    begin
      sync_act_reg <= `ADCSCP_RST_SYNC_CTRL;
      armed_reg <= 1'h0;
      resync_reg <= 1'h0;
    end
    else
    begin
      resync_reg <= sync_fire; // RULE20
      if (xfer_reg)
        sync_act_reg <= sync_sh_reg; // RULE22
      if (xfer_reg && sync_sh_reg[`ADCSCP_SYNC_EN_BIT] && sync_sh_reg[`ADCSCP_SYNC_NEXT_BIT])
        armed_reg <= 1'h1;
      else if (sync_fire)
        armed_reg <= 1'h0; // RULE20
    end
  end

  reg [1:0] strap_cnt_reg;
  reg strap_arm_reg;
  reg strap_done_reg;
  reg strap_valid_reg;
  reg strap_sclk_reg;
  reg strap_sdio_reg;
  reg secondary_reg;
  always @(posedge CLK)
  begin
    if (RST)
    begin
      strap_cnt_reg <= 2'h0;
      strap_arm_reg <= 1'h0;
      strap_done_reg <= 1'h0;
      strap_valid_reg <= 1'h0;
      strap_sclk_reg <= 1'h0;
      strap_sdio_reg <= 1'h0;
      secondary_reg <= 1'h0;
    end
    else
    begin
      secondary_reg <= csb_lvl & (state_reg == ST_INSTR) & (bit_cnt_reg == 4'h0); // RULE5
      // Wait for the pin pipeline to settle before sampling straps
      if (strap_cnt_reg != `ADCSCP_STRAP_WAIT)
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      // Filter level lands one edge after the count ends
      else if (!strap_arm_reg)
        strap_arm_reg <= 1'h1;
      else if (!strap_done_reg)
      begin
        strap_done_reg <= 1'h1;
        if (csb_lvl) // RULE12
        begin
          strap_valid_reg <= 1'h1;
          strap_sclk_reg <= sclk_lvl;
          strap_sdio_reg <= sdi_lvl;
        end
      end
    end
  end

  assign SDIO_O = sdo_reg;
  assign SDIO_OE_N = ~drive_reg; // RULE9
  assign SPI_SECONDARY_EN = secondary_reg;
  assign STRAP_VALID = strap_valid_reg;
  assign STRAP_SCLK_FUNC = strap_sclk_reg;
  assign STRAP_SDIO_FUNC = strap_sdio_reg;
  assign DIV_RESYNC = resync_reg;
  assign SYNC_ARMED = armed_reg;
  assign NS_EN_A = en_w[0];
  assign NS_EN_B = en_w[1];
  assign NS_MODE_A = mode_w[2:0];
  assign NS_MODE_B = mode_w[5:3];
  assign NS_WIDE_A = wide_w[0];
  assign NS_WIDE_B = wide_w[1];
  assign NS_TW_A = tw_w[5:0];
  assign NS_TW_B = tw_w[11:6];
  assign NS_TW_OK_A = ok_w[0];
  assign NS_TW_OK_B = ok_w[1];
  assign NS_LO_A = lo_w[7:0];
  assign NS_LO_B = lo_w[15:8];
  assign NS_CTR_A = ctr_w[7:0];
  assign NS_CTR_B = ctr_w[15:8];
  assign NS_HI_A = hi_w[7:0];
  assign NS_HI_B = hi_w[15:8];

endmodule // adcscp_top

// file: adcscp_checker.sv
`timescale 1ns/100ps
module adcscp_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CSB_N,
  input wire logic SDIO_OE_N,
  input wire logic SPI_SECONDARY_EN,
  input wire logic STRAP_VALID,
  input wire logic STRAP_SCLK_FUNC,
  input wire logic STRAP_SDIO_FUNC,
  input wire logic DIV_RESYNC,
  input wire logic SYNC_ARMED,
  input wire logic NS_EN_A,
  input wire logic NS_EN_B,
  input wire logic [2:0] NS_MODE_A,
  input wire logic [2:0] NS_MODE_B,
  input wire logic NS_WIDE_B,
  input wire logic [5:0] NS_TW_A,
  input wire logic NS_TW_OK_A,
  input wire logic [7:0] NS_LO_A,
  input wire logic [7:0] NS_CTR_A,
  input wire logic [7:0] NS_HI_A,
  input wire logic [7:0] NS_LO_B,
  input wire logic [7:0] NS_CTR_B,
  input wire logic [7:0] NS_HI_B
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Seven cycles covers the pin filter plus the output register
  chk_oe_idle: assert property (CSB_N [*7] |-> SDIO_OE_N)
    else $error("data line driven while deselected");
  chk_sec_busy: assert property (!CSB_N [*7] |-> !SPI_SECONDARY_EN)
    else $error("secondary functions on during select");
  chk_strap_hold: assert property (STRAP_VALID |=> STRAP_VALID && $stable({STRAP_SCLK_FUNC, STRAP_SDIO_FUNC}))
    else $error("strap levels moved after latching");
  chk_resync_one: assert property (DIV_RESYNC |=> !DIV_RESYNC)
    else $error("resync pulse longer than one cycle");
  chk_arm_fire: assert property ($fell(SYNC_ARMED) |-> (DIV_RESYNC || $past(DIV_RESYNC)) or ##1 DIV_RESYNC)
    else $error("disarmed without a resync");
  chk_ns_update: assert property ($changed(NS_TW_A) |-> !$past(CSB_N, 2))
    else $error("tuning changed outside a serial frame");
  chk_tw_range: assert property (NS_EN_A |-> NS_TW_OK_A == ((NS_MODE_A == 3'h0 && NS_TW_A <= 6'h38) || (NS_MODE_A == 3'h1 && NS_TW_A <= 6'h21)))
    else $error("tuning range flag wrong");
  chk_band_narrow: assert property (NS_EN_A && NS_MODE_A == 3'h0 |-> NS_LO_A == {2'b00, NS_TW_A} && NS_CTR_A == NS_LO_A + 8'h16 && NS_HI_A == NS_LO_A + 8'h2c)
    else $error("narrow band edges wrong");
  chk_band_wide: assert property (NS_EN_B && NS_MODE_B == 3'h1 |-> NS_CTR_B == NS_LO_B + 8'h21 && NS_HI_B == NS_LO_B + 8'h42)
    else $error("wide band edges wrong");
  chk_wide_flag: assert property (NS_WIDE_B == (NS_MODE_B == 3'h1))
    else $error("wide flag does not follow mode");
  cov_read: cover property ($fell(SDIO_OE_N));
  cov_resync: cover property (DIV_RESYNC);
  cov_wide: cover property (NS_EN_B && NS_WIDE_B);
endmodule // adcscp_checker

bind adcscp_top adcscp_checker chk (.CLK(CLK), .RST(RST), .CSB_N(CSB_N), .SDIO_OE_N(SDIO_OE_N),
  .SPI_SECONDARY_EN(SPI_SECONDARY_EN), .STRAP_VALID(STRAP_VALID),
  .STRAP_SCLK_FUNC(STRAP_SCLK_FUNC), .STRAP_SDIO_FUNC(STRAP_SDIO_FUNC),
  .DIV_RESYNC(DIV_RESYNC), .SYNC_ARMED(SYNC_ARMED), .NS_EN_A(NS_EN_A), .NS_EN_B(NS_EN_B),
  .NS_MODE_A(NS_MODE_A), .NS_MODE_B(NS_MODE_B), .NS_WIDE_B(NS_WIDE_B), .NS_TW_A(NS_TW_A),
  .NS_TW_OK_A(NS_TW_OK_A), .NS_LO_A(NS_LO_A), .NS_CTR_A(NS_CTR_A), .NS_HI_A(NS_HI_A),
  .NS_LO_B(NS_LO_B), .NS_CTR_B(NS_CTR_B), .NS_HI_B(NS_HI_B));

// file: adcscp_master.sv
`timescale 1ns/100ps
module adcscp_master (
  input wire CLK,
  output logic SCLK,
  output logic CSB_N,
  output wire SDIO_W,
  input wire SDIO_O,
  input wire SDIO_OE_N
);
  logic drv;
  logic mval;
  logic lsb;
  // Released line shows the inverse of the last bit, never a stale copy
  assign SDIO_W = !SDIO_OE_N ? SDIO_O : (drv ? mval : !mval);
  initial
  begin
    SCLK = 1'b0;
    CSB_N = 1'b1;
    drv = 1'b0;
    mval = 1'b0;
    lsb = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Ten-cycle phases keep SCLK inside the pin filter limit
  task automatic bitx(input logic b, input logic d, output logic r);
    drv <= d;
    mval <= d ? b : mval;
    cyc(10);
    SCLK <= 1'b1;
    r = SDIO_W;
    cyc(10);
    SCLK <= 1'b0;
  endtask
  // SCLK stands still outside frames
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a,
    input int n, input int stall, inout logic [31:0] d);
    logic [15:0] ins;
    logic [7:0] by;
    logic r;
    ins = {rd, len, a};
    @(posedge CLK);
    CSB_N <= 1'b0;
    for (int i = 0; i < 16; i++)
      bitx(ins[lsb ? i : 15 - i], 1'b1, r);
    for (int k = 0; k < n; k++)
    begin
      if (k == stall)
      begin
        cyc(10);
        CSB_N <= 1'b1;
        cyc(20);
        CSB_N <= 1'b0;
      end
      by = d[31 - 8 * k -: 8];
      for (int i = 0; i < 8; i++)
      begin
        bitx(by[lsb ? i : 7 - i], !rd, r);
        by[lsb ? i : 7 - i] = r;
      end
      d[31 - 8 * k -: 8] = by;
    end
    cyc(10);
    CSB_N <= 1'b1;
    cyc(20);
  endtask
endmodule // adcscp_master

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic rst;
  logic sync_in;
  wire sclk, csb_n, sdio_w, sdio_o, oe_n, sec, sv, ssf, sdf, res, arm;
  wire en_a, en_b, wide_a, wide_b, ok_a, ok_b;
  wire [2:0] ma, mb;
  wire [5:0] ta, tw_b;
  wire [7:0] la, lb, ca, cb, ha, hb;
  int miscompares = 0;
  int checked = 0;
  adcscp_master m (.CLK(clk), .SCLK(sclk), .CSB_N(csb_n), .SDIO_W(sdio_w), .SDIO_O(sdio_o),
    .SDIO_OE_N(oe_n));
  adcscp_top dut (.CLK(clk), .RST(rst), .SCLK(sclk), .CSB_N(csb_n), .SDIO_I(sdio_w),
    .SDIO_O(sdio_o), .SDIO_OE_N(oe_n), .SYNC_IN(sync_in), .SPI_SECONDARY_EN(sec),
    .STRAP_VALID(sv), .STRAP_SCLK_FUNC(ssf), .STRAP_SDIO_FUNC(sdf), .DIV_RESYNC(res),
    .SYNC_ARMED(arm), .NS_EN_A(en_a), .NS_EN_B(en_b), .NS_MODE_A(ma), .NS_MODE_B(mb),
    .NS_WIDE_A(wide_a), .NS_WIDE_B(wide_b), .NS_TW_A(ta), .NS_TW_B(tw_b), .NS_TW_OK_A(ok_a),
    .NS_TW_OK_B(ok_b), .NS_LO_A(la), .NS_LO_B(lb), .NS_CTR_A(ca), .NS_CTR_B(cb),
    .NS_HI_A(ha), .NS_HI_B(hb));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    logic [31:0] d;
    d = {v, 24'h00_0000};
    m.xfer(1'b0, 2'b00, a, 1, -1, d);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    logic [31:0] d;
    d = 32'h0000_0000;
    m.xfer(1'b1, 2'b00, a, 1, -1, d);
    v = d[31:24];
  endtask
  task automatic pulses(output int n);
    n = 0;
    repeat (2)
    begin
      sync_in <= 1'b1;
      repeat (10) @(posedge clk) n += res;
      sync_in <= 1'b0;
      repeat (10) @(posedge clk) n += res;
    end
  endtask
  task automatic t_reset;
    logic [7:0] v;
    check("secondary_en", 8'(sec), 8'h01);
    check("strap_valid", 8'(sv), 8'h01);
    check("strap_sclk", 8'(ssf), 8'h00);
    check("strap_sdio", 8'(sdf), 8'h01);
    rd(13'h0005, v);
    check("chan_idx", v, 8'h03);
    rd(13'h003e, v);
    check("tune_reset", v, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_narrow;
    logic [7:0] v;
    wr(13'h0005, 8'h01);
    wr(13'h003c, 8'h01);
    wr(13'h003e, 8'h38);
    check("en_a_shadow", 8'(en_a), 8'h00);
    wr(13'h00ff, 8'h01);
    check("en_a", 8'(en_a), 8'h01);
    check("wide_a", 8'(wide_a), 8'h00);
    check("mode_a", 8'(ma), 8'h00);
    check("ok_a", 8'(ok_a), 8'h01);
    check("lo_a", la, 8'h38);
    check("ctr_a", ca, 8'h4e);
    check("hi_a", ha, 8'h64);
    check("en_b", 8'(en_b), 8'h00);
    rd(13'h00ff, v);
    check("xfer_clear", v, 8'h00);
    $display("test narrow done");
  endtask
  task automatic t_wide;
    logic [7:0] v;
    wr(13'h0005, 8'h02);
    wr(13'h003c, 8'h03);
    wr(13'h003e, 8'h22);
    wr(13'h00ff, 8'h01);
    check("wide_b", 8'(wide_b), 8'h01);
    check("mode_b", 8'(mb), 8'h01);
    check("ok_b_34", 8'(ok_b), 8'h00);
    check("lo_b", lb, 8'h22);
    check("ctr_b", cb, 8'h43);
    wr(13'h003e, 8'h21);
    wr(13'h00ff, 8'h01);
    check("ok_b_33", 8'(ok_b), 8'h01);
    check("tw_b", 8'(tw_b), 8'h21);
    check("hi_b", hb, 8'h63);
    check("tw_a_kept", 8'(ta), 8'h38);
    wr(13'h0005, 8'h03);
    rd(13'h003e, v);
    check("both_read_a", v, 8'h38);
    $display("test wide done");
  endtask
  task automatic t_sync;
    int n;
    wr(13'h003a, 8'h02);
    wr(13'h00ff, 8'h01);
    pulses(n);
    check("every_pulse", 8'(n), 8'h02);
    wr(13'h003a, 8'h06);
    wr(13'h00ff, 8'h01);
    check("armed", 8'(arm), 8'h01);
    pulses(n);
    check("next_only", 8'(n), 8'h01);
    check("disarmed", 8'(arm), 8'h00);
    $display("test sync done");
  endtask
  task automatic t_lsb;
    logic [7:0] v;
    // Symmetric byte lands the same in either bit order
    wr(13'h0000, 8'h42);
    m.lsb = 1'b1;
    wr(13'h003e, 8'h0d);
    rd(13'h003e, v);
    check("lsb_read", v, 8'h0d);
    wr(13'h0000, 8'h00);
    m.lsb = 1'b0;
    rd(13'h003e, v);
    check("msb_read", v, 8'h0d);
    $display("test lsb done");
  endtask
  task automatic t_stream;
    logic [31:0] d;
    logic [7:0] v;
    d = 32'h0500_0600;
    m.xfer(1'b0, 2'b10, 13'h003c, 3, 1, d);
    rd(13'h003c, v);
    check("stall_3c", v, 8'h05);
    rd(13'h003a, v);
    check("stall_3a", v, 8'h06);
    d = 32'h0b00_0200;
    m.xfer(1'b0, 2'b11, 13'h003c, 3, -1, d);
    rd(13'h003c, v);
    check("stream_3c", v, 8'h0b);
    rd(13'h003a, v);
    check("stream_3a", v, 8'h02);
    d = 32'h0000_0000;
    m.xfer(1'b1, 2'b01, 13'h003c, 2, -1, d);
    check("two_byte_3c", d[31:24], 8'h0b);
    check("two_byte_3b", d[23:16], 8'h00);
    // Mode 101 is neither band: range flag off, edges collapse onto the word
    wr(13'h00ff, 8'h01);
    check("ok_a_other", 8'(ok_a), 8'h00);
    check("hi_a_other", ha, 8'h0d);
    $display("test stream done");
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    sync_in = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset;
    t_narrow;
    t_wide;
    t_sync;
    t_lsb;
    t_stream;
    final_report;
  end
  // About 32 frames of roughly 500 cycles each
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule // tb_top
